/* File: common/qbp_pkg.sv */
package qbp_pkg;
    // ==========================================================
    // Port geometry and reset values
    // ==========================================================
    localparam int          PORT_COUNT  = 4;
    localparam int          PORT_WIDTH  = 8;
    localparam logic [7:0]  LATCH_RESET = 8'hff;
    localparam logic [7:0]  LATCH_FORCE = 8'hff;
    localparam logic [7:0]  SYNC_RESET  = 8'hff;
    localparam logic [7:0]  RD_RESET    = 8'h00;
    localparam logic [3:0]  SLOT_RESET  = 4'h0;
    // ==========================================================
    // Port indices
    // ==========================================================
    localparam logic [1:0]  PORT_ZERO   = 2'h0;
    localparam logic [1:0]  PORT_ONE    = 2'h1;
    localparam logic [1:0]  PORT_TWO    = 2'h2;
    localparam logic [1:0]  PORT_THREE  = 2'h3;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int          CLK_PER_MC  = 12;
    localparam logic [3:0]  SLOT_LAST   = 4'hb;
    localparam int          SYNC_STAGES = 2;
endpackage

/* File: sim/qbp_board.sv */
`timescale 1ns/1ns
module qbp_board (
    input  wire logic [31:0] drv_in,
    input  wire logic [31:0] oe_in,
    input  wire logic [31:0] lvl_in,
    output logic      [31:0] pin_out
);
    // Released lines follow pull-up or external device level
    assign pin_out = (oe_in & drv_in) | (~oe_in & lvl_in);
endmodule

/* File: sim/qbp_ports_asserts.sv */
`timescale 1ns/1ns
module qbp_ports_asserts (
    input wire logic clk_in, sys_rst_in, wr_strobe_in, rmw_read_in,
    input wire logic ext_bus_in, ext_drive_in, ext_data_in_in, slot_last_out,
    input wire logic [1:0] port_sel_in,
    input wire logic [7:0] wr_data_in, rd_data_out, ext_addr_lo_in,
    input wire logic [7:0] ext_addr_hi_in, port_zero_out, port_zero_oe_out,
    input wire logic [7:0] port_one_out, port_one_oe_out, port_two_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    chk_rst_release: assert property ($fell(sys_rst_in) |->
        port_one_oe_out == 8'h00 && rd_data_out == 8'h00) else $error("rst");
    chk_low_only: assert property ((port_one_oe_out & port_one_out) == 0)
        else $error("high drive");
    chk_od_float: assert property (!ext_bus_in |->
        (port_zero_oe_out & port_zero_out) == 8'h00) else $error("p0 high");
    chk_rx_release: assert property (ext_bus_in && ext_data_in_in |->
        port_zero_oe_out == 8'h00) else $error("p0 rx");
    chk_bus_drive: assert property (ext_bus_in && ext_drive_in &&
        !ext_data_in_in |->
        port_zero_oe_out == 8'hff && port_zero_out == ext_addr_lo_in)
        else $error("p0 bus");
    chk_hi_addr: assert property (ext_bus_in |->
        port_two_out == ext_addr_hi_in) else $error("p2 bus");
    chk_slot_period: assert property (slot_last_out |->
        ##12 slot_last_out) else $error("slot");
    chk_latch_read: assert property (wr_strobe_in && !ext_bus_in ##1
        $stable(port_sel_in) && rmw_read_in && !ext_bus_in |=>
        rd_data_out == $past(wr_data_in, 2)) else $error("latch read");
    cover property (wr_strobe_in && rmw_read_in);
    cover property (ext_bus_in && ext_drive_in);
    cover property (ext_bus_in && ext_data_in_in);
endmodule
bind qbp_ports qbp_ports_asserts chk_u (.*);

/* File: sim/quasi_bidir_io_ports_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module quasi_bidir_io_ports_tb;
    import qbp_pkg::*;
    logic clk_in = 0, sys_rst_in = 1, wr_strobe_in = 0, rmw_read_in = 0;
    logic ext_bus_in = 0, ext_drive_in = 0, ext_data_in_in = 0, slot_last_out;
    logic [1:0] port_sel_in = 0;
    logic [7:0] wr_data_in = 0, rd_data_out, ext_addr_lo_in = 0;
    logic [7:0] ext_addr_hi_in = 0, port_zero_out, port_one_out, port_two_out;
    wire  [7:0] port_zero_in, port_one_in, port_two_in, port_three_in;
    logic [7:0] port_three_out, port_zero_oe_out, port_one_oe_out;
    logic [7:0] port_two_oe_out, port_three_oe_out;
    logic [31:0] lvl = '1;
    int n_mismatch = 0, checked = 0, lat[4], v;
    always #5 clk_in = ~clk_in;
    qbp_ports dut_u (.*);
    qbp_board brd_u (.drv_in({port_three_out, port_two_out, port_one_out,
        port_zero_out}), .oe_in({port_three_oe_out, port_two_oe_out,
        port_one_oe_out, port_zero_oe_out}), .lvl_in(lvl), .pin_out({
        port_three_in, port_two_in, port_one_in, port_zero_in}));
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input int s, input int d);
        @(posedge clk_in);
        port_sel_in <= 2'(s);
        wr_data_in <= 8'(d);
        wr_strobe_in <= 1'b1;
        @(posedge clk_in);
        wr_strobe_in <= 1'b0;
        if (!(s == 0 && ext_bus_in)) lat[s] = d & 255;
    endtask
    task automatic rd(input int s, input logic r, input int e);
        @(posedge clk_in);
        port_sel_in <= 2'(s);
        rmw_read_in <= r;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK("rd_data_out", 8'(e), rd_data_out)
    endtask
    // Wait for the machine cycle end, then the pin update edge
    task automatic sync_pins;
        #1;
        for (v = 0; v < 30 && slot_last_out !== 1'b1; v++) @(posedge clk_in) #1;
        if (v == 30) begin n_mismatch++; print_verdict(); end
        @(posedge clk_in) #1;
    endtask
    initial begin
        void'($urandom(32'h589918ef));
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        for (int p = 0; p < 4; p++) rd(p, 1, 255);
        `CHK("oe", 8'h00, port_three_oe_out | port_zero_oe_out)
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            wr(p, $urandom);
            rd(p, 1, lat[p]);
            wr(p, lat[p] ^ 90);
            rd(p, 1, lat[p]);
        end
        $display("test latch done");
        wr(1, 15);
        wr(3, 255);
        wr(0, 255);
        sync_pins();
        `CHK("oe1", 8'hf0, port_one_oe_out)
        lvl = $urandom | 32'h0000ff00;
        rd(1, 0, 15);
        rd(3, 0, lvl[31:24]);
        rd(0, 0, lvl[7:0]);
        $display("test pins done");
        wr(0, 0);
        @(posedge clk_in);
        ext_bus_in <= 1'b1;
        ext_data_in_in <= 1'b1;
        ext_addr_hi_in <= 8'($urandom);
        lat[0] = 255;
        wr(0, 60);
        rd(0, 1, lat[0]);
        rd(2, 1, lat[2]);
        `CHK("oe0 rx", 8'h00, port_zero_oe_out)
        `CHK("p2 addr", ext_addr_hi_in, port_two_out)
        @(posedge clk_in);
        ext_data_in_in <= 1'b0;
        ext_drive_in <= 1'b1;
        ext_addr_lo_in <= 8'($urandom);
        rd(0, 1, lat[0]);
        `CHK("oe0 drv", 8'hff, port_zero_oe_out)
        `CHK("p0 addr", ext_addr_lo_in, port_zero_out)
        $display("test bus done");
        print_verdict();
    end
endmodule

/* File: src/qbp_ports.sv */
`timescale 1ns/1ns
// Operation
// [R01] Thirty-two lines in four 8-bit ports, each line input or output.
// [R02] Latch bit 0 turns on pull-down, driving pin low.
// [R03] Latch bit 1 releases pull-down; pull-up raises quasi-bidirectional pins.
// [R04] Software writes 1 to a latch bit before using it as input.
// [R05] Reset sets all latch bits high, so every line is input.
// [R06] Latch captures internal bus value on port write strobe.
// [R07] Two reads per port: latch value and pin level.
// [R08] Ports one to three are quasi-bidirectional; input needs latch high.
// [R09] Port zero as I/O is open-drain, floating when latch high.
// [R10] Port zero upper driver active only as external memory bus.
// [R11] Port zero external bus input forces its latch to ones.
// [R12] External bus disconnects latches; zero set to ones, two holds.
// [R13] Read-modify-write uses latch value and writes result back.
// [R14] New latch value reaches pin after next machine cycle end.
// [R15] Pin reads pass through a two-stage synchronizer.
module qbp_ports
    import qbp_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [1:0]  port_sel_in,
    input  wire logic        wr_strobe_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        rmw_read_in,
    output logic      [7:0]  rd_data_out,
    input  wire logic        ext_bus_in,
    input  wire logic        ext_drive_in,
    input  wire logic        ext_data_in_in,
    input  wire logic [7:0]  ext_addr_lo_in,
    input  wire logic [7:0]  ext_addr_hi_in,
    input  wire logic [7:0]  port_zero_in,
    input  wire logic [7:0]  port_one_in,
    input  wire logic [7:0]  port_two_in,
    input  wire logic [7:0]  port_three_in,
    output logic      [7:0]  port_zero_out,
    output logic      [7:0]  port_zero_oe_out,
    output logic      [7:0]  port_one_out,
    output logic      [7:0]  port_one_oe_out,
    output logic      [7:0]  port_two_out,
    output logic      [7:0]  port_two_oe_out,
    output logic      [7:0]  port_three_out,
    output logic      [7:0]  port_three_oe_out,
    output logic             slot_last_out
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [3:0][7:0] latch;
        logic [3:0][7:0] stage;
        logic [3:0][7:0] sync_a;
        logic [3:0][7:0] sync_b;
        logic [3:0]      slot;
        logic [7:0]      rd_data;
    } qbp_state_s;

    qbp_state_s      st;
    qbp_state_s      next_st;
    logic [3:0][7:0] pins;
    logic [7:0]      drv_zero;
    logic [7:0]      oe_zero;
    logic [7:0]      drv_two;
    logic [7:0]      oe_two;
    logic            bus_drive;
    logic            bus_receive;

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Select one port row of a four-port array
    function automatic logic [7:0] qbp_pick(
        input logic [3:0][7:0] rows,
        input logic [1:0]      idx
    );
        logic [7:0] row;
        row = rows[PORT_ZERO];
        if (idx == PORT_ONE) begin
            row = rows[PORT_ONE];
        end else if (idx == PORT_TWO) begin
            row = rows[PORT_TWO];
        end else if (idx == PORT_THREE) begin
            row = rows[PORT_THREE];
        end
        return row;
    endfunction

    // Pull-down enable: on where the staged latch bit is low
    function automatic logic [7:0] qbp_pull_down(
        input logic [7:0] stage
    );
        return ~stage;
    endfunction

    // Machine cycle slot step, wrapping after the last slot
    function automatic logic [3:0] qbp_slot_next(
        input logic [3:0] slot
    );
        logic [3:0] nxt;
        if (slot == SLOT_LAST) begin
            nxt = SLOT_RESET;
        end else begin
            nxt = slot + 4'h1;
        end
        return nxt;
    endfunction

    // ==========================================================
    // Pin gathering
    // ==========================================================
    // All 32 lines seen as four rows of eight
    assign pins = {port_three_in, port_two_in, port_one_in, port_zero_in}; // [R01]

    // Bus phases of port zero
    assign bus_receive = ext_bus_in && ext_data_in_in;
    assign bus_drive   = ext_bus_in && ext_drive_in && !ext_data_in_in;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        next_st = st;
        // Machine cycle slot counter
        next_st.slot = qbp_slot_next(st.slot);
        // Output stage samples latch once per machine cycle
        if (st.slot == SLOT_LAST) begin
            next_st.stage = st.latch; // [R14]
        end
        // Two-stage pin synchronizer; only sync_b is read
        next_st.sync_a = pins; // [R15]
        next_st.sync_b = st.sync_a; // [R15]
        // Latch write, also read-modify-write write-back
        for (int p = 0; p < PORT_COUNT; p++) begin
            if (wr_strobe_in && port_sel_in == 2'(p)) begin
                next_st.latch[p] = wr_data_in; // [R06] [R13]
            end
        end
        // Bus use of port zero forces latch high, over any write
        if (ext_bus_in) begin
            next_st.latch[PORT_ZERO] = LATCH_FORCE; // [R11] [R12]
        end
        // Latch read for read-modify-write, else synchronized pins
        if (rmw_read_in) begin
            next_st.rd_data = qbp_pick(st.latch, port_sel_in); // [R07] [R13]
        end else begin
            next_st.rd_data = qbp_pick(st.sync_b, port_sel_in); // [R07] [R15]
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st.latch   <= {PORT_COUNT{LATCH_RESET}}; // [R05]
            st.stage   <= {PORT_COUNT{LATCH_RESET}};
            st.sync_a  <= {PORT_COUNT{SYNC_RESET}};
            st.sync_b  <= {PORT_COUNT{SYNC_RESET}};
            st.slot    <= SLOT_RESET;
            st.rd_data <= RD_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Output stages
    // ==========================================================
    // Port zero: bus drive, bus receive, or open-drain I/O
    always_comb begin
        drv_zero = 8'h00;
        oe_zero  = 8'h00;
        if (bus_drive) begin
            drv_zero = ext_addr_lo_in; // [R10]
            oe_zero  = 8'hff; // [R10]
        end else if (bus_receive) begin
            drv_zero = 8'h00;
            oe_zero  = 8'h00; // [R11]
        end else if (ext_bus_in) begin
            drv_zero = 8'h00;
            oe_zero  = 8'h00; // [R12]
        end else begin
            drv_zero = 8'h00; // [R09]
            oe_zero  = qbp_pull_down(st.stage[PORT_ZERO]); // [R02] [R09]
        end
    end
    assign port_zero_out    = drv_zero;
    assign port_zero_oe_out = oe_zero;

    // Port two: high address on the bus, latch held and unseen
    always_comb begin
        if (ext_bus_in) begin
            drv_two = ext_addr_hi_in; // [R12]
            oe_two  = 8'hff; // [R12]
        end else begin
            drv_two = st.stage[PORT_TWO]; // [R03] [R08]
            oe_two  = qbp_pull_down(st.stage[PORT_TWO]); // [R02]
        end
    end
    assign port_two_out    = drv_two;
    assign port_two_oe_out = oe_two;

    // Quasi ports: low driven hard, high released to pull-up
    // Strong pull-up pulse on a rising edge is left to the pad
    assign port_one_out      = st.stage[PORT_ONE]; // [R03] [R08]
    assign port_one_oe_out   = qbp_pull_down(st.stage[PORT_ONE]); // [R02]
    assign port_three_out    = st.stage[PORT_THREE]; // [R03] [R08]
    assign port_three_oe_out = qbp_pull_down(st.stage[PORT_THREE]); // [R02]

    // ==========================================================
    // Read data and slot marker
    // ==========================================================
    assign rd_data_out   = st.rd_data;
    assign slot_last_out = (st.slot == SLOT_LAST);
endmodule
